// ==== shared/uebc_pkg.sv ====
// Purpose: Constants for the endpoint buffer configuration block.
// Assumes: 16-bit register port, byte offsets as printed.
// Notes: Offsets are register addresses on the plain port.
package uebc_pkg;
    // =========================================================
    // Register offsets
    localparam logic [7:0] UEBC_OFF_INDEX = 8'h2C;
    localparam logic [7:0] UEBC_OFF_PKT_SIZE = 8'h04;
    localparam logic [7:0] UEBC_OFF_TYPE = 8'h08;
    localparam logic [7:0] UEBC_OFF_LENGTH = 8'h1C;
    localparam logic [7:0] UEBC_OFF_FILL = 8'h1E;
    // =========================================================
    // Field positions
    localparam int UEBC_FSZ_MSB = 10;
    localparam int UEBC_NTR_LSB = 11;
    localparam int UEBC_NTR_MSB = 12;
    localparam int UEBC_KIND_MSB = 1;
    localparam int UEBC_DBL_BIT = 2;
    localparam int UEBC_EN_BIT = 3;
    localparam int UEBC_NOE_BIT = 4;
    // Writable masks (reserved bits read zero)
    localparam logic [15:0] UEBC_PKT_MASK = 16'h1FFF;
    localparam logic [15:0] UEBC_TYPE_MASK = 16'h001F;
    // Reset values
    localparam logic [15:0] UEBC_RST_WORD = 16'h0000;
    localparam logic [1:0] UEBC_RST_FILL = 2'h0;
    // =========================================================
    // Endpoint kind codes
    localparam logic [1:0] UEBC_KIND_UNUSED = 2'h0;
    localparam logic [1:0] UEBC_KIND_ISO = 2'h1;
    localparam logic [1:0] UEBC_KIND_BULK = 2'h2;
    localparam logic [1:0] UEBC_KIND_INTR = 2'h3;
    // Transactions per microframe codes
    localparam logic [1:0] UEBC_NTR_RESERVED = 2'h3;
    // Control endpoint index
    localparam logic [3:0] UEBC_CTRL_EP = 4'h0;
endpackage : uebc_pkg

// ==== verilog/uebc_fill_tracker.sv ====
// Purpose: Two-buffer fill state of one data endpoint.
// Assumes: Fill and drain pulses come from the packet engine, same clock.
// Notes: Fill state is a pair of flags; drain applies before fill, so both take effect.
module uebc_fill_tracker
    import uebc_pkg::*;
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_bus_reset,
    // Configuration
    input wire logic i_double,
    input wire logic i_enable,
    // Events
    input wire logic i_fill,
    input wire logic i_drain,
    // Status
    output logic [1:0] o_state
);
    typedef struct packed {
        logic [1:0] fill; // Bit per buffer
        logic wr_sel;     // Next buffer to fill
        logic rd_sel;     // Next buffer to drain
    } uebc_trk_t;

    uebc_trk_t s_reg;
    uebc_trk_t s_next;

    // =========================================================
    // Next state
    always_comb begin
        s_next = s_reg;
        // Drain first so a same-cycle fill is not lost
        if (i_drain && s_next.fill[s_reg.rd_sel]) begin
            s_next.fill[s_reg.rd_sel] = 1'b0;
            s_next.rd_sel = i_double ? ~s_reg.rd_sel : 1'b0;
        end
        // Test the drained copy so a fill into a buffer freed this cycle lands
        if (i_fill && !s_next.fill[s_reg.wr_sel]) begin
            s_next.fill[s_reg.wr_sel] = 1'b1;
            s_next.wr_sel = i_double ? ~s_reg.wr_sel : 1'b0;
        end
        // Disabled endpoint holds no packets
        if (!i_enable || i_bus_reset) begin
            s_next = '0;
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign o_state = s_reg.fill;
endmodule : uebc_fill_tracker

// ==== verilog/uebc_endpoint_config.sv ====
// Purpose: Indexed per-endpoint buffer configuration and status registers.
// Assumes: Firmware writes the index first and observes its own waits.
// Notes: All outputs registered; read data valid the cycle after a read.
//
// Summary of operation
// - 16-bit packet byte count per endpoint
// - Fill state meaningless for control endpoint
// - Fill state 00/01/10/11, zero after resets
// - Packet-size write reloads packet byte count
// - Transactions code 00..10 gives 1..3, 11 reserved
// - Transactions only for high-speed iso or interrupt
// - 11-bit FIFO size, same both speeds
// - Packet size excludes setup and control endpoints
// - Type register selects kind in bits 1:0
// - Enable bit 3, double buffer bit 2
// - Bit 4 suppresses automatic null packet
// - Kind 01 iso, 10 bulk, 11 interrupt
// - Null packet after DMA IN unless suppressed
// - Enable bit enables endpoint FIFO
// - Double-buffer bit gives two buffers
//
// The plain strobed port was decided locally.
module uebc_endpoint_config
    import uebc_pkg::*;
#(
    parameter int NUM_EP = 16,
    parameter int IDX_W = 4
)
(
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // USB bus reset, a pin level
    input wire logic i_bus_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    // Link state
    input wire logic i_high_speed,
    // Packet engine events, same clock, one-cycle pulses
    input wire logic [IDX_W-1:0] i_evt_ep,
    input wire logic i_evt_fill,
    input wire logic i_evt_drain,
    input wire logic i_evt_out_len,
    input wire logic [15:0] i_evt_len,
    input wire logic i_dma_in_done,
    // Configuration of the engine's current endpoint
    output logic [10:0] o_ep_fifo_size,
    output logic o_ep_enable,
    output logic o_ep_double,
    output logic [1:0] o_ep_kind,
    output logic [1:0] o_ep_packets_per_uframe,
    output logic o_send_null_packet
);
    // =========================================================
    // State
    typedef struct packed {
        logic [IDX_W-1:0] index;
        logic [NUM_EP-1:0][15:0] pkt_size;
        logic [NUM_EP-1:0][4:0] type_cfg;
        logic [NUM_EP-1:0][15:0] byte_count;
        logic [15:0] rdata;
        logic [10:0] ep_fifo_size;
        logic ep_enable;
        logic ep_double;
        logic [1:0] ep_kind;
        logic [1:0] ep_ppu;
        logic send_null;
    } uebc_state_t;

    uebc_state_t s_reg;
    uebc_state_t s_next;

    // Bus reset synchroniser; only stage two is read by logic
    logic bus_rst_s1_reg;
    logic bus_rst_s2_reg;
    // Fill state from each endpoint tracker
    logic [NUM_EP-1:0][1:0] fill_state;

    // =========================================================
    // Packets per microframe from the code and endpoint kind
    function automatic logic [1:0] uebc_ppu(input logic [1:0] code,
                                            input logic [1:0] kind,
                                            input logic hs);
        logic periodic;
        periodic = (kind == UEBC_KIND_ISO) || (kind == UEBC_KIND_INTR);
        // Only periodic high-speed endpoints get extra transactions
        if (!hs || !periodic) begin
            uebc_ppu = 2'h1;
        end else if (code == UEBC_NTR_RESERVED) begin
            uebc_ppu = 2'h1; // Reserved code treated as one packet
        end else begin
            uebc_ppu = code + 2'h1;
        end
    endfunction : uebc_ppu

    // =========================================================
    // Bus reset synchroniser
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            bus_rst_s1_reg <= 1'b0;
            bus_rst_s2_reg <= 1'b0;
        end else begin
            bus_rst_s1_reg <= i_bus_reset;
            bus_rst_s2_reg <= bus_rst_s1_reg;
        end
    end

    // =========================================================
    // Fill trackers, one per data endpoint
    genvar g;
    generate
        for (g = 0; g < NUM_EP; g++) begin : g_trk
            if (g == 0) begin : g_ctrl
                // Control endpoint has no double buffer status
                assign fill_state[g] = 2'h0;
            end else begin : g_data
                uebc_fill_tracker u_trk (
                    .i_clock(i_clock),
                    .i_rst(i_rst),
                    .i_bus_reset(bus_rst_s2_reg),
                    .i_double(s_reg.type_cfg[g][UEBC_DBL_BIT]),
                    .i_enable(s_reg.type_cfg[g][UEBC_EN_BIT]),
                    .i_fill(i_evt_fill && (i_evt_ep == IDX_W'(g))),
                    .i_drain(i_evt_drain && (i_evt_ep == IDX_W'(g))),
                    .o_state(fill_state[g])
                );
            end
        end
    endgenerate

    // =========================================================
    // Register access and engine view
    always_comb begin
        logic [4:0] tc;
        logic [15:0] pk;
        tc = s_reg.type_cfg[i_evt_ep];
        pk = s_reg.pkt_size[i_evt_ep];
        s_next = s_reg;
        s_next.rdata = 16'h0000;
        // Engine-side OUT length capture
        if (i_evt_out_len) begin
            s_next.byte_count[i_evt_ep] = i_evt_len;
        end
        // Writes reach the copy selected by the index
        if (i_wr) begin
            unique case (i_addr)
                UEBC_OFF_INDEX: s_next.index = i_wdata[IDX_W-1:0];
                UEBC_OFF_PKT_SIZE: begin
                    s_next.pkt_size[s_reg.index] = i_wdata & UEBC_PKT_MASK;
                    s_next.byte_count[s_reg.index] =
                        {5'h00, i_wdata[UEBC_FSZ_MSB:0]};
                end
                UEBC_OFF_TYPE: begin
                    s_next.type_cfg[s_reg.index] = i_wdata[4:0];
                end
                UEBC_OFF_LENGTH: s_next.byte_count[s_reg.index] = i_wdata;
                default: begin
                    // Unmapped or read-only: write ignored
                end
            endcase
        end
        // Reads return data in the following cycle
        if (i_rd) begin
            unique case (i_addr)
                UEBC_OFF_INDEX: s_next.rdata = 16'(s_reg.index);
                UEBC_OFF_PKT_SIZE: s_next.rdata = s_reg.pkt_size[s_reg.index];
                UEBC_OFF_TYPE: s_next.rdata = {11'h000, s_reg.type_cfg[s_reg.index]};
                UEBC_OFF_LENGTH: s_next.rdata = s_reg.byte_count[s_reg.index];
                UEBC_OFF_FILL: s_next.rdata = {14'h0000, fill_state[s_reg.index]};
                default: s_next.rdata = 16'h0000;
            endcase
        end
        // Engine view of its current endpoint
        if (i_evt_ep == UEBC_CTRL_EP) begin
            // Control endpoint is sized elsewhere
            s_next.ep_fifo_size = 11'h000;
            s_next.ep_ppu = 2'h1;
        end else begin
            s_next.ep_fifo_size = pk[UEBC_FSZ_MSB:0];
            s_next.ep_ppu = uebc_ppu(pk[UEBC_NTR_MSB:UEBC_NTR_LSB],
                                     tc[UEBC_KIND_MSB:0], i_high_speed);
        end
        s_next.ep_enable = tc[UEBC_EN_BIT];
        s_next.ep_double = tc[UEBC_DBL_BIT];
        s_next.ep_kind = tc[UEBC_KIND_MSB:0];
        // Null packet once DMA IN completes unless suppressed
        s_next.send_null = i_dma_in_done && !tc[UEBC_NOE_BIT];
        // Bus reset clears endpoint configuration and counts
        if (bus_rst_s2_reg) begin
            s_next.pkt_size = '0;
            s_next.type_cfg = '0;
            s_next.byte_count = '0;
        end
    end

    // =========================================================
    // State register
    always_ff @(posedge i_clock) begin
        if (i_rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // =========================================================
    // Outputs straight from flip-flops
    assign o_rdata = s_reg.rdata;
    assign o_ep_fifo_size = s_reg.ep_fifo_size;
    assign o_ep_enable = s_reg.ep_enable;
    assign o_ep_double = s_reg.ep_double;
    assign o_ep_kind = s_reg.ep_kind;
    assign o_ep_packets_per_uframe = s_reg.ep_ppu;
    assign o_send_null_packet = s_reg.send_null;
endmodule : uebc_endpoint_config

// ==== verif/uebc_cfg_monitor.sv ====
// Purpose: Port checks of the endpoint configuration block.
// Assumes: One clock domain, synchronous reset.
// Notes: Bound into every instance of the block.
module uebc_cfg_monitor
    import uebc_pkg::*;
#(parameter int NUM_EP = 16, parameter int IDX_W = 4)
(
    // Register port
    input wire logic i_clock, i_rst, i_bus_reset, i_wr, i_rd,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata, o_rdata,
    // Engine side
    input wire logic [IDX_W-1:0] i_evt_ep,
    input wire logic i_evt_out_len, i_dma_in_done, o_send_null_packet,
    input wire logic [10:0] o_ep_fifo_size
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // ==========
    // Write, one quiet cycle, then the read that should see it
    sequence s_wr(a);
        i_wr && i_addr == a && !i_bus_reset ##1 !i_wr && !i_evt_out_len;
    endsequence
    sequence s_rd(a);
        i_rd && i_addr == a && !i_evt_out_len;
    endsequence
    chk_type_readback: assert property (s_wr(UEBC_OFF_TYPE) ##1 s_rd(UEBC_OFF_TYPE)
        |=> o_rdata == ($past(i_wdata, 3) & UEBC_TYPE_MASK)) else $error("type readback");
    chk_len_reload: assert property (s_wr(UEBC_OFF_PKT_SIZE) ##1 s_rd(UEBC_OFF_LENGTH)
        |=> o_rdata == ($past(i_wdata, 3) & 16'h07FF)) else $error("length not reloaded");
    chk_null_cause: assert property (o_send_null_packet |-> $past(i_dma_in_done))
        else $error("null packet without DMA end");
    chk_type_rsvd: assert property ($past(i_rd) && $past(i_addr) == UEBC_OFF_TYPE
        |-> (o_rdata & ~UEBC_TYPE_MASK) == 16'h0000) else $error("type reserved bits");
    chk_size_rsvd: assert property ($past(i_rd) && $past(i_addr) == UEBC_OFF_PKT_SIZE
        |-> (o_rdata & ~UEBC_PKT_MASK) == 16'h0000) else $error("size reserved bits");
    chk_fill_rsvd: assert property ($past(i_rd) && $past(i_addr) == UEBC_OFF_FILL
        |-> o_rdata[15:2] == 14'h0000) else $error("fill reserved bits");
    chk_ctrl_size: assert property ($past(i_evt_ep) == UEBC_CTRL_EP
        |-> o_ep_fifo_size == 11'h000) else $error("control endpoint size");
    chk_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
        else $error("read data outside read slot");
endmodule : uebc_cfg_monitor
bind uebc_endpoint_config uebc_cfg_monitor #(.NUM_EP(NUM_EP), .IDX_W(IDX_W)) u_mon (
    .i_clock(i_clock), .i_rst(i_rst), .i_bus_reset(i_bus_reset), .i_wr(i_wr),
    .i_rd(i_rd), .i_addr(i_addr), .i_wdata(i_wdata), .o_rdata(o_rdata),
    .i_evt_ep(i_evt_ep), .i_evt_out_len(i_evt_out_len), .i_dma_in_done(i_dma_in_done),
    .o_send_null_packet(o_send_null_packet), .o_ep_fifo_size(o_ep_fifo_size));

// ==== verif/uebc_engine_model.sv ====
// Purpose: Packet engine stand-in raising fill, drain, length and DMA pulses.
// Assumes: Pulses last one clock; endpoint select holds between pulses.
// Notes: Length bus shows the inverse of its last value when idle.
module uebc_engine_model
(
    input wire logic i_clock,
    output logic [3:0] o_ep,
    output logic o_fill, o_drain, o_out_len, o_dma_done,
    output logic [15:0] o_len
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_ep, o_fill, o_drain, o_out_len, o_dma_done, o_len} = '0;
    end
    // Kind 0 fill, 1 drain, 2 length load, 3 DMA end, 4 only selects
    task automatic pulse(input int k, input logic [3:0] ep, input logic [15:0] len);
        @(posedge i_clock);
        o_ep <= ep;
        o_len <= len;
        {o_fill, o_drain, o_out_len, o_dma_done} <= 4'h8 >> k;
        @(posedge i_clock);
        {o_fill, o_drain, o_out_len, o_dma_done} <= 4'h0;
        o_len <= ~len;
    endtask : pulse
endmodule : uebc_engine_model

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the endpoint configuration block.
// Assumes: 125 MHz clock, reset held four cycles.
// Notes: Index writes and firmware waits are kept by the tasks.
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("[FAIL] %0t got %h want %h", $time, (g), (e)); end end
module tb_top
    import uebc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, bus_rst = 0, hs = 1, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wd = 16'h0000, rdata, ev_len;
    logic [3:0] ev_ep;
    logic ev_fill, ev_drain, ev_olen, ev_dma, en, dbl, nul;
    logic [10:0] fsz;
    logic [1:0] kind, ppu;
    int miscompares = 0, total_checks = 0;
    always #4 clk = ~clk;
    uebc_engine_model eng (.i_clock(clk), .o_ep(ev_ep), .o_fill(ev_fill),
        .o_drain(ev_drain), .o_out_len(ev_olen), .o_dma_done(ev_dma), .o_len(ev_len));
    uebc_endpoint_config #(.NUM_EP(16), .IDX_W(4)) dut (.i_clock(clk), .i_rst(rst),
        .i_bus_reset(bus_rst), .i_addr(addr), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
        .o_rdata(rdata), .i_high_speed(hs), .i_evt_ep(ev_ep), .i_evt_fill(ev_fill),
        .i_evt_drain(ev_drain), .i_evt_out_len(ev_olen), .i_evt_len(ev_len),
        .i_dma_in_done(ev_dma), .o_ep_fifo_size(fsz), .o_ep_enable(en), .o_ep_double(dbl),
        .o_ep_kind(kind), .o_ep_packets_per_uframe(ppu), .o_send_null_packet(nul));
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wreg
    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask : rreg
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] d;
        rreg(a, d);
        `CHK(d, e)
    endtask : rchk
    task automatic zchk();
        rchk(UEBC_OFF_TYPE, 16'h0000);
        rchk(UEBC_OFF_PKT_SIZE, 16'h0000);
        rchk(UEBC_OFF_LENGTH, 16'h0000);
        rchk(UEBC_OFF_FILL, 16'h0000);
    endtask : zchk
    // Engine view lags the register by one cycle
    task automatic vchk(input logic [1:0] k, input logic [1:0] p);
        repeat (2) @(posedge clk);
        `CHK({kind, ppu}, {k, p})
    endtask : vchk
    task automatic t_config();
        wreg(UEBC_OFF_INDEX, 16'h0001);
        zchk();
        wreg(UEBC_OFF_PKT_SIZE, 16'hFFFF);
        rchk(UEBC_OFF_LENGTH, 16'h07FF);
        rchk(UEBC_OFF_PKT_SIZE, 16'h1FFF);
        wreg(UEBC_OFF_PKT_SIZE, 16'h0840);
        rchk(UEBC_OFF_LENGTH, 16'h0040);
        wreg(UEBC_OFF_INDEX, 16'h0002);
        wreg(UEBC_OFF_TYPE, 16'hFFEA);
        rchk(UEBC_OFF_TYPE, 16'h000A);
        wreg(UEBC_OFF_INDEX, 16'h0001);
        rchk(UEBC_OFF_PKT_SIZE, 16'h0840);
        eng.pulse(4, 4'h1, 16'h0000);
        for (int k = 1; k < 4; k++) begin
            wreg(UEBC_OFF_TYPE, 16'h000C | 16'(k));
            vchk(2'(k), k == 2 ? 2'h1 : 2'h2);
            `CHK({en, dbl, fsz}, {2'b11, 11'h040})
        end
        wreg(UEBC_OFF_TYPE, 16'h0009);
        for (int c = 0; c < 4; c++) begin
            wreg(UEBC_OFF_PKT_SIZE, 16'(c << 11) | 16'h0040);
            vchk(2'h1, c == 3 ? 2'h1 : 2'(c + 1));
        end
        wreg(UEBC_OFF_PKT_SIZE, 16'h1040);
        hs <= 1'b0;
        vchk(2'h1, 2'h1);
        hs <= 1'b1;
        vchk(2'h1, 2'h3);
        $display("test config done");
    endtask : t_config
    task automatic t_fill();
        logic [15:0] d;
        wreg(UEBC_OFF_TYPE, 16'h000E);
        eng.pulse(0, 4'h1, 16'h0000);
        repeat (26) @(posedge clk);
        rreg(UEBC_OFF_FILL, d);
        `CHK(d == 16'h0001 || d == 16'h0002, 1'b1)
        eng.pulse(0, 4'h1, 16'h0000);
        repeat (26) @(posedge clk);
        rchk(UEBC_OFF_FILL, 16'h0003);
        for (int i = 0; i < 2; i++) begin
            eng.pulse(1, 4'h1, 16'h0000);
        end
        repeat (26) @(posedge clk);
        wreg(UEBC_OFF_FILL, 16'h0003);
        rchk(UEBC_OFF_FILL, 16'h0000);
        eng.pulse(0, 4'h0, 16'h0000);
        wreg(UEBC_OFF_INDEX, 16'h0000);
        repeat (26) @(posedge clk);
        rchk(UEBC_OFF_FILL, 16'h0000);
        wreg(UEBC_OFF_INDEX, 16'h0001);
        $display("test fill done");
    endtask : t_fill
    task automatic t_misc();
        for (int s = 0; s < 2; s++) begin
            wreg(UEBC_OFF_TYPE, 16'h000A | 16'(s << 4));
            eng.pulse(3, 4'h1, 16'h0000);
            @(posedge clk);
            `CHK(nul, s == 0)
        end
        eng.pulse(2, 4'h1, 16'h0123);
        rchk(UEBC_OFF_LENGTH, 16'h0123);
        wreg(UEBC_OFF_LENGTH, 16'h8005);
        rchk(UEBC_OFF_LENGTH, 16'h8005);
        rchk(8'h10, 16'h0000);
        eng.pulse(0, 4'h1, 16'h0000);
        bus_rst <= 1'b1;
        repeat (4) @(posedge clk);
        bus_rst <= 1'b0;
        repeat (4) @(posedge clk);
        zchk();
        $display("test misc done");
    endtask : t_misc
    task automatic wrap_up();
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_config();
        t_fill();
        t_misc();
        wrap_up();
    end
    // Whole run needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        wrap_up();
    end
endmodule : tb_top
